/* src/flash_link_pkg.sv */
package flash_link_pkg;

  // Clock rate and the durations that derive cycle counts from it.
  localparam int CLK_HZ       = 10_000_000;
  localparam int EP_TYP_MS    = 15;
  localparam int EP_MAX_MS    = 55;
  localparam int OTP_TYP_US   = 200;
  localparam int OTP_MAX_US   = 500;
  localparam int CS_HIGH_NS   = 30;

  // A longest time rounds down, a least time rounds up, never below one cycle.
  localparam int EP_TYP_CYCLES  = EP_TYP_MS * (CLK_HZ / 1000);
  localparam int EP_MAX_CYCLES  = EP_MAX_MS * (CLK_HZ / 1000);
  localparam int OTP_TYP_CYCLES = OTP_TYP_US * (CLK_HZ / 1_000_000);
  localparam int OTP_MAX_CYCLES = OTP_MAX_US * (CLK_HZ / 1_000_000);
  localparam int CS_HIGH_RAW    = (CS_HIGH_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int CS_HIGH_CYCLES = (CS_HIGH_RAW < 1) ? 1 : CS_HIGH_RAW;

  // Maintenance span in cumulative page erase and program operations.
  localparam int REWRITE_SPAN_OPS = 50_000;

  // Structural defaults.
  localparam int SCK_HALF_DEF   = 2;
  localparam int PAGES_DEF      = 16;
  localparam int PAGE_BYTES_DEF = 8;
  localparam int FIFO_DEPTH_DEF = 32;
  localparam int TIMER_W        = 20;
  localparam int BITS_W         = 12;
  localparam int HEADER_BITS    = 16;
  localparam int STATUS_BUSY_BIT = 0;

  // Command bytes on the serial link.
  localparam logic [7:0] CODE_PROGRAM     = 8'h02;
  localparam logic [7:0] CODE_READ        = 8'h03;
  localparam logic [7:0] CODE_STATUS      = 8'h05;
  localparam logic [7:0] CODE_OTP_PROGRAM = 8'h42;
  localparam logic [7:0] CODE_OTP_READ    = 8'h4B;
  localparam logic [7:0] CODE_REWRITE     = 8'h58;

  typedef enum logic [2:0] {
    OP_PROGRAM     = 3'h0,
    OP_READ        = 3'h1,
    OP_OTP_PROGRAM = 3'h2,
    OP_OTP_READ    = 3'h3,
    OP_REWRITE     = 3'h4,
    OP_STATUS      = 3'h5
  } op_e;

  // Operation to command byte.
  function automatic logic [7:0] op_code(input op_e o);
    unique case (o)
      OP_PROGRAM:     op_code = CODE_PROGRAM;
      OP_READ:        op_code = CODE_READ;
      OP_OTP_PROGRAM: op_code = CODE_OTP_PROGRAM;
      OP_OTP_READ:    op_code = CODE_OTP_READ;
      OP_REWRITE:     op_code = CODE_REWRITE;
      default:        op_code = CODE_STATUS;
    endcase
  endfunction

  // Command byte to operation; unknown bytes fall back to a harmless status read.
  function automatic op_e code_op(input logic [7:0] c);
    unique case (c)
      CODE_PROGRAM:     code_op = OP_PROGRAM;
      CODE_READ:        code_op = OP_READ;
      CODE_OTP_PROGRAM: code_op = OP_OTP_PROGRAM;
      CODE_OTP_READ:    code_op = OP_OTP_READ;
      CODE_REWRITE:     code_op = OP_REWRITE;
      default:          code_op = OP_STATUS;
    endcase
  endfunction

  // Operations that start an internal program cycle.
  function automatic logic is_program(input op_e o);
    is_program = (o == OP_PROGRAM) || (o == OP_OTP_PROGRAM) || (o == OP_REWRITE);
  endfunction

endpackage

/* src/flash_link_if.sv */
`timescale 1ns/1ns
interface flash_link_if;
  logic cs_n;
  logic sck;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic dev_reset_n;

  modport device (
    input  cs_n,
    input  sck,
    input  mosi,
    input  dev_reset_n,
    output miso,
    output miso_oe
  );

  modport host (
    output cs_n,
    output sck,
    output mosi,
    output dev_reset_n,
    input  miso,
    input  miso_oe
  );
endinterface

/* src/flash_device.sv */
`timescale 1ns/1ns
module flash_device
  import flash_link_pkg::*;
#(
  parameter int PAGES      = flash_link_pkg::PAGES_DEF,
  parameter int PAGE_BYTES = flash_link_pkg::PAGE_BYTES_DEF,
  parameter int EP_CYCLES  = flash_link_pkg::EP_TYP_CYCLES
) (
  input  wire logic      clk,
  input  wire logic      reset,
  input  wire logic      ce,
  flash_link_if.device   link,
  output logic           busy,
  output logic           op_done
);
  import flash_link_pkg::*;

  localparam int PAW = $clog2(PAGES);
  localparam int PBW = $clog2(PAGE_BYTES);

  typedef enum logic {DEV_IDLE = 1'b0, DEV_BUSY = 1'b1} dev_state_e;

  typedef struct packed {
    dev_state_e                         st;
    logic                               cs_n_prev;
    logic                               armed;
    logic                               sck_prev;
    logic                               mosi_prev;
    logic [BITS_W-1:0]                  nbits;
    logic [7:0]                         rx;
    logic [7:0]                         tx;
    logic                               miso;
    logic                               oe;
    op_e                                op;
    logic [7:0]                         page;
    logic [TIMER_W-1:0]                 timer;
    logic                               done;
    logic [PAGES*PAGE_BYTES-1:0][7:0]   mem;
    logic [PAGE_BYTES-1:0][7:0]         otp;
  } dev_s;

  dev_s q;
  dev_s d;

  //////////////////////////////////////////////////////////////////////////////
  // Serial engine and program timer.
  //////////////////////////////////////////////////////////////////////////////

  // Byte index within the frame and offset into a page.
  logic [BITS_W-4:0] idx;
  logic [PBW-1:0]    off;
  logic [7:0]        b;

  // Link inputs are compared with their registered copies, so an edge is acted on in the cycle the pin changes.
  always_comb begin
    d   = q;
    idx = q.nbits[BITS_W-1:3];
    off = PBW'(idx - (BITS_W-3)'(2));
    b   = 8'h00;
    if (ce) begin
      d.done      = 1'b0;
      d.cs_n_prev = link.cs_n;
      d.sck_prev  = link.sck;
      d.mosi_prev = link.mosi;
      d.oe        = !link.cs_n;
      // Internal program cycle runs to its fixed duration, well inside the maximum.
      if (q.st == DEV_BUSY) begin
        if (q.timer <= TIMER_W'(1)) begin
          d.st   = DEV_IDLE;
          d.done = 1'b1;
        end else begin
          d.timer = q.timer - TIMER_W'(1);
        end
      end
      if (!link.cs_n) begin
        if (link.sck && !q.sck_prev && !q.armed) begin
          // The first rise of a frame only launches; no host bit stands on the line before it.
          d.armed = 1'b1;
        end else if (link.sck && !q.sck_prev) begin
          // Rising edge: take the level that stood before the edge, not the new bit.
          b       = {q.rx[6:0], q.mosi_prev};
          d.rx    = b;
          d.nbits = q.nbits + BITS_W'(1);
          if (q.nbits[2:0] == 3'h7) begin
            if (idx == '0) begin
              d.op = code_op(b);
            end else if (idx == (BITS_W-3)'(1)) begin
              d.page = b;
            end else if (q.st == DEV_IDLE && q.op == OP_PROGRAM) begin
              d.mem[{q.page[PAW-1:0], off}] = b;
            end else if (q.st == DEV_IDLE && q.op == OP_OTP_PROGRAM) begin
              d.otp[off] = q.otp[off] & b; // Bits only ever clear, so it programs once.
            end
          end
        end else if (!link.sck && q.sck_prev && q.nbits != '0) begin
          // Falling edge launches; a mode 3 lead-in fall has no bit yet and is ignored.
          if (q.nbits[2:0] == 3'h0) begin
            if (q.op == OP_STATUS) begin
              b = 8'h00;
              b[STATUS_BUSY_BIT] = (q.st == DEV_BUSY);
            end else if (q.op == OP_READ && idx >= (BITS_W-3)'(2)) begin
              b = q.mem[{q.page[PAW-1:0], off}];
            end else if (q.op == OP_OTP_READ && idx >= (BITS_W-3)'(2)) begin
              b = q.otp[off];
            end
            d.miso = b[7];
            d.tx   = {b[6:0], 1'b0};
          end else begin
            d.miso = q.tx[7];
            d.tx   = {q.tx[6:0], 1'b0};
          end
        end
      end else begin
        d.nbits = '0;
        d.miso  = 1'b0;
        d.armed = 1'b0;
        // The program cycle starts when the select rises after a whole header.
        if (!q.cs_n_prev && q.st == DEV_IDLE && is_program(q.op) && q.nbits >= BITS_W'(HEADER_BITS)) begin
          d.st    = DEV_BUSY;
          d.timer = (q.op == OP_OTP_PROGRAM) ? TIMER_W'(OTP_TYP_CYCLES) : TIMER_W'(EP_CYCLES);
        end
      end
      // Hardware reset pin clears control state but leaves the array intact.
      if (!link.dev_reset_n) begin
        d.st    = DEV_IDLE;
        d.nbits = '0;
        d.miso  = 1'b0;
        d.timer = '0;
        d.armed = 1'b0;
        d.op    = OP_STATUS;
      end
    end
  end

  // State register.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      q <= '{st: DEV_IDLE, cs_n_prev: 1'b1, op: OP_STATUS, mem: '1, otp: '1, default: '0};
    end else begin
      q <= d;
    end
  end

  assign link.miso    = q.miso;
  assign link.miso_oe = q.oe;
  assign busy         = q.st;
  assign op_done      = q.done;

endmodule

/* src/flash_host.sv */
`timescale 1ns/1ns

//////////////////////////////////////////////////////////////////////////////
// Write data buffer between user and serial engine.
//////////////////////////////////////////////////////////////////////////////
module flash_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = flash_link_pkg::FIFO_DEPTH_DEF
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             ce,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
    logic                        full;
    logic                        empty;
  } fifo_s;

  fifo_s q;
  fifo_s d;
  logic  push;
  logic  pop;

  // Flags are registered so the ready seen by the source never depends on the sink.
  always_comb begin
    d    = q;
    push = ce && in_valid && !q.full;
    pop  = ce && out_ready && !q.empty;
    if (push) begin
      d.mem[q.wp] = in_data;
      d.wp        = q.wp + AW'(1);
    end
    if (pop) begin
      d.rp = q.rp + AW'(1);
    end
    d.cnt   = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    d.full  = (d.cnt == (AW+1)'(DEPTH));
    d.empty = (d.cnt == '0);
  end

  // State register.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      q <= '{empty: 1'b1, default: '0};
    end else begin
      q <= d;
    end
  end

  assign in_ready  = !q.full;
  assign out_valid = !q.empty;
  assign out_data  = q.mem[q.rp];

endmodule

//////////////////////////////////////////////////////////////////////////////
// Host controller: serial master, completion wait and rewrite maintenance.
//////////////////////////////////////////////////////////////////////////////
module flash_host
  import flash_link_pkg::*;
#(
  parameter int SCK_HALF     = flash_link_pkg::SCK_HALF_DEF,
  parameter int PAGES        = flash_link_pkg::PAGES_DEF,
  parameter int FIFO_DEPTH   = flash_link_pkg::FIFO_DEPTH_DEF,
  parameter int EP_MAX       = flash_link_pkg::EP_MAX_CYCLES,
  parameter int OTP_MAX      = flash_link_pkg::OTP_MAX_CYCLES,
  parameter int REWRITE_SPAN = flash_link_pkg::REWRITE_SPAN_OPS,
  parameter bit LAZY_REWRITE = 1'b0
) (
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire logic                  ce,
  input  wire logic                  spi_mode3,
  input  wire logic                  cmd_valid,
  output logic                       cmd_ready,
  input  wire flash_link_pkg::op_e   cmd_op,
  input  wire logic [7:0]            cmd_page,
  input  wire logic [7:0]            cmd_len,
  input  wire logic                  wr_valid,
  output logic                       wr_ready,
  input  wire logic [7:0]            wr_data,
  output logic                       rd_valid,
  output logic [7:0]                 rd_data,
  output logic                       done,
  output logic [$clog2(PAGES)-1:0]   rewrite_ptr,
  flash_link_if.host                 link
);
  import flash_link_pkg::*;

  localparam int PAW      = $clog2(PAGES);
  localparam int INTERVAL = LAZY_REWRITE ? REWRITE_SPAN : REWRITE_SPAN / PAGES;

  typedef enum logic [1:0] {H_IDLE = 2'b00, H_XFER = 2'b01, H_GAP = 2'b11, H_POLL = 2'b10} host_state_e;

  typedef struct packed {
    host_state_e          st;
    logic                 cs_n;
    logic                 sck;
    logic                 mosi;
    logic                 dev_rst_n;
    logic [7:0]           half;
    logic [BITS_W-1:0]    rises;
    logic [BITS_W-1:0]    tbits;
    logic                 closing;
    op_e                  op;
    logic [7:0]           page;
    logic [7:0]           tx;
    logic [7:0]           rx;
    logic                 polling;
    logic                 busy_seen;
    logic [TIMER_W-1:0]   wait_cnt;
    logic [TIMER_W-1:0]   lim;
    logic [3:0]           gap;
    logic [16:0]          ops_cnt;
    logic [PAW+1:0]       pending;
    logic [PAW-1:0]       ptr;
    logic                 cmd_ready;
    logic                 rd_valid;
    logic [7:0]           rd_data;
    logic                 done;
  } host_s;

  host_s       q;
  host_s       d;
  logic        pop;
  logic        fifo_valid;
  logic [7:0]  fifo_data;
  logic [7:0]  b;
  logic [BITS_W-1:0] s;

  flash_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) wbuf (
    .clk       (clk),
    .reset     (reset),
    .ce        (ce),
    .in_valid  (wr_valid),
    .in_ready  (wr_ready),
    .in_data   (wr_data),
    .out_valid (fifo_valid),
    .out_ready (pop),
    .out_data  (fifo_data)
  );

  // One process holds the whole controller; a stalled write buffer freezes the clock.
  always_comb begin
    d   = q;
    pop = 1'b0;
    b   = 8'h00;
    s   = q.rises - BITS_W'(2);
    if (ce) begin
      d.rd_valid  = 1'b0;
      d.done      = 1'b0;
      d.dev_rst_n = q.dev_rst_n | q.cs_n;
      if (q.polling && q.wait_cnt != '1) begin
        d.wait_cnt = q.wait_cnt + TIMER_W'(1);
      end
      unique case (q.st)
        H_IDLE: begin
          d.sck = spi_mode3;
          if (q.dev_rst_n && (q.pending != '0 || (cmd_valid && q.cmd_ready))) begin
            if (q.pending != '0) begin
              d.op      = OP_REWRITE;
              d.page    = 8'(q.ptr);
              d.ptr     = q.ptr + PAW'(1);
              d.pending = q.pending - (PAW+2)'(1);
              d.tbits   = BITS_W'(HEADER_BITS);
            end else begin
              d.op      = cmd_op;
              d.page    = cmd_page;
              d.tbits   = BITS_W'(HEADER_BITS) + {1'b0, cmd_len, 3'h0};
            end
            if (d.op == OP_PROGRAM || d.op == OP_REWRITE) begin
              if (q.ops_cnt + 17'(1) >= 17'(INTERVAL)) begin
                d.ops_cnt = '0;
                d.pending = d.pending + (LAZY_REWRITE ? (PAW+2)'(PAGES) : (PAW+2)'(1));
              end else begin
                d.ops_cnt = q.ops_cnt + 17'(1);
              end
            end
            d.cs_n    = 1'b0;
            d.sck     = spi_mode3;
            d.rises   = '0;
            d.closing = 1'b0;
            d.half    = 8'(SCK_HALF - 1);
            d.st      = H_XFER;
          end
        end
        H_XFER: begin
          if (q.half != 8'h00) begin
            d.half = q.half - 8'h01;
          end else if (!q.sck) begin
            // Rising edge: launch the next bit while the device takes the last one.
            d.half = 8'(SCK_HALF - 1);
            if (q.closing) begin
              d.sck = 1'b1;
            end else if (q.rises < q.tbits && q.rises[2:0] == 3'h0) begin
              if (q.rises[BITS_W-1:3] == '0) begin
                b = op_code(q.op);
              end else if (q.rises[BITS_W-1:3] == (BITS_W-3)'(1)) begin
                b = q.page;
              end else if (q.op == OP_PROGRAM || q.op == OP_OTP_PROGRAM) begin
                b   = fifo_data;
                pop = fifo_valid;
              end
              if (fifo_valid || q.rises[BITS_W-1:3] < (BITS_W-3)'(2) || !(q.op == OP_PROGRAM || q.op == OP_OTP_PROGRAM)) begin
                d.mosi  = b[7];
                d.tx    = {b[6:0], 1'b0};
                d.sck   = 1'b1;
                d.rises = q.rises + BITS_W'(1);
              end else begin
                d.half = 8'h00; // Buffer empty: hold the clock low until data arrives.
              end
            end else if (q.rises < q.tbits) begin
              d.mosi  = q.tx[7];
              d.tx    = {q.tx[6:0], 1'b0};
              d.sck   = 1'b1;
              d.rises = q.rises + BITS_W'(1);
            end else begin
              d.sck   = 1'b1;
              d.rises = q.rises + BITS_W'(1);
            end
          end else begin
            // Falling edge: take the bit the device launched one whole period earlier.
            d.half = 8'(SCK_HALF - 1);
            d.sck  = 1'b0;
            if (q.rises >= BITS_W'(2)) begin
              d.rx = {q.rx[6:0], link.miso};
              if (s[2:0] == 3'h7) begin
                if (q.op == OP_STATUS && s[BITS_W-1:3] == (BITS_W-3)'(1)) begin
                  d.busy_seen = d.rx[STATUS_BUSY_BIT];
                end else if ((q.op == OP_READ || q.op == OP_OTP_READ) && s[BITS_W-1:3] >= (BITS_W-3)'(2)) begin
                  d.rd_valid = 1'b1;
                  d.rd_data  = d.rx;
                end
              end
            end
            if (q.rises == q.tbits + BITS_W'(1)) begin
              d.closing = 1'b1;
            end
          end
          // Frame ends with the last fall, or with the return to idle high in mode 3.
          if ((q.half == 8'h00 && q.sck && q.rises == q.tbits + BITS_W'(1) && !spi_mode3) ||
              (q.half == 8'h00 && !q.sck && q.closing)) begin
            d.cs_n = 1'b1;
            d.mosi = 1'b0;
            d.gap  = 4'(CS_HIGH_CYCLES);
            d.st   = H_GAP;
            if (is_program(q.op)) begin
              d.polling   = 1'b1;
              d.busy_seen = 1'b1;
              d.wait_cnt  = '0;
              d.lim       = (q.op == OP_OTP_PROGRAM) ? TIMER_W'(OTP_MAX) : TIMER_W'(EP_MAX);
            end else if (q.op != OP_STATUS) begin
              d.done = 1'b1;
            end
          end
        end
        H_GAP: begin
          if (q.gap <= 4'h1) begin
            d.st = q.polling ? H_POLL : H_IDLE;
          end else begin
            d.gap = q.gap - 4'h1;
          end
        end
        H_POLL: begin
          // Wait for a clear busy bit or the longest duration, whichever comes first.
          if (!q.busy_seen || q.wait_cnt >= q.lim) begin
            d.polling = 1'b0;
            d.done    = 1'b1;
            d.st      = H_IDLE;
          end else begin
            d.op      = OP_STATUS;
            d.tbits   = BITS_W'(HEADER_BITS);
            d.cs_n    = 1'b0;
            d.sck     = spi_mode3;
            d.rises   = '0;
            d.closing = 1'b0;
            d.half    = 8'(SCK_HALF - 1);
            d.st      = H_XFER;
          end
        end
      endcase
      d.cmd_ready = (d.st == H_IDLE) && (d.pending == '0) && d.dev_rst_n;
    end
  end

  // State register; reset loads device reset low and select high, and device reset rises on the next enabled cycle.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      q <= '{st: H_IDLE, cs_n: 1'b1, op: OP_STATUS, default: '0};
    end else begin
      q <= d;
    end
  end

  assign link.cs_n        = q.cs_n;
  assign link.sck         = q.sck;
  assign link.mosi        = q.mosi;
  assign link.dev_reset_n = q.dev_rst_n;
  assign cmd_ready        = q.cmd_ready;
  assign rd_valid         = q.rd_valid;
  assign rd_data          = q.rd_data;
  assign done             = q.done;
  assign rewrite_ptr      = q.ptr;

endmodule

/* testbench/flash_link_monitor.sv */
`timescale 1ns/1ns
module flash_link_monitor (
  input wire logic clk,
  input wire logic reset,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe,
  input wire logic dev_reset_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  //////////////////////////////////////////////////////////////////////////////
  // A frame carries at least sixteen bits, so select stays low well past eight clocks.
  sequence s_select_held;
    !cs_n [*8];
  endsequence
  sequence s_clock_edge;
    $changed(sck);
  endsequence

  // Every serial clock level lasts at least two system clocks at the half period used here.
  a_half_period: assert property (s_clock_edge |=> $stable(sck))
    else $error("serial clock level lasted one cycle");
  a_frame_length: assert property ($fell(cs_n) |-> s_select_held)
    else $error("select frame too short");
  a_mosi_on_rise: assert property (!cs_n && $changed(mosi) |-> $rose(sck))
    else $error("host data moved away from a rising clock");
  a_miso_low_phase: assert property (!cs_n && !$past(cs_n) && sck && $past(sck) |-> $stable(miso))
    else $error("device data moved while clock high");
  a_oe_follows_select: assert property (miso_oe == !$past(cs_n))
    else $error("output enable does not follow select");
  a_select_clock_quiet: assert property ($fell(cs_n) |-> $stable(sck))
    else $error("clock moved as select fell");
  a_reset_order: assert property ($rose(dev_reset_n) |-> cs_n && $past(cs_n))
    else $error("device reset released with select low");
  a_reset_stays_off: assert property ($past(dev_reset_n) |-> dev_reset_n)
    else $error("device reset asserted again");
endmodule

/* testbench/test_serial_flash_clocking_and_rewrite.sv */
`timescale 1ns/1ns
module test_serial_flash_clocking_and_rewrite;
  import flash_link_pkg::*;
  logic       clk, reset, spi_mode3, cmd_valid, cmd_ready, wr_valid, wr_ready;
  logic       rd_valid, done, busy, op_done, otp_run;
  op_e        cmd_op;
  logic [7:0] cmd_page, cmd_len, wr_data, rd_data;
  logic [3:0] rewrite_ptr;
  logic [7:0] mem [16][8];
  logic [7:0] otp_m [8];
  logic [7:0] expect_q [$];
  int         errors, samples_checked, run;

  flash_link_if link ();
  flash_device #(.EP_CYCLES(40)) i_flash_device (.clk(clk), .reset(reset), .ce(1'b1), .link(link),
    .busy(busy), .op_done(op_done));
  flash_host #(.EP_MAX(200), .REWRITE_SPAN(64)) i_flash_host (.clk(clk), .reset(reset), .ce(1'b1),
    .spi_mode3(spi_mode3), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
    .cmd_page(cmd_page), .cmd_len(cmd_len), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_data(wr_data), .rd_valid(rd_valid), .rd_data(rd_data), .done(done),
    .rewrite_ptr(rewrite_ptr), .link(link));
  flash_link_monitor i_flash_link_monitor (.clk(clk), .reset(reset), .cs_n(link.cs_n), .sck(link.sck),
    .mosi(link.mosi), .miso(link.miso), .miso_oe(link.miso_oe), .dev_reset_n(link.dev_reset_n));

  //////////////////////////////////////////////////////////////////////////////
  // Free-running system clock.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Compare one observed value with its expectation.
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task print_verdict;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Hold a command until taken, then wait a bounded time for its completion pulse.
  task send(input op_e op, input logic [7:0] page, input logic [7:0] len);
    int n;
    n = 0;
    cmd_op = op;
    cmd_page = page;
    cmd_len = len;
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1) @(posedge clk) #1;
    @(posedge clk) #1 cmd_valid = 1'b0;
    while (done !== 1'b1 && n < 20000) begin
      @(posedge clk) #1;
      n++;
    end
    if (n >= 20000) check(1'b0, 1'b1);
    @(posedge clk) #1;
  endtask

  // Valid stays up between bytes so it never toggles within one time step; callers drop it.
  task push(input logic [7:0] d);
    wr_data = d;
    wr_valid = 1'b1;
    while (wr_ready !== 1'b1) @(posedge clk) #1;
    @(posedge clk) #1;
  endtask

  // Random bytes go through the buffer; offsets wrap inside the page, so the last ones win.
  task prog(input logic [3:0] page, input int len);
    logic [7:0] d;
    for (int i = 0; i < len; i++) begin
      d = $urandom;
      mem[page][i % 8] = d;
      push(d);
    end
    wr_valid = 1'b0;
    if (len == 32) begin
      @(posedge clk) #1;
      check(wr_ready, 1'b0);
    end
    send(OP_PROGRAM, {4'h0, page}, len[7:0]);
  endtask

  task rd(input logic [3:0] page, input bit otp);
    for (int i = 0; i < 8; i++) expect_q.push_back(otp ? otp_m[i] : mem[page][i]);
    send(otp ? OP_OTP_READ : OP_READ, {4'h0, page}, 8'h08);
    check(expect_q.size(), 0);
  endtask

  // Each read byte is matched against the oldest note; busy spans are bounded.
  always @(posedge clk) begin
    if (rd_valid && expect_q.size() == 0) check(1'b1, 1'b0);
    else if (rd_valid) check(rd_data, expect_q.pop_front());
    if (busy === 1'b1) run++;
    else if (run > 0) begin
      check(run <= (otp_run ? 5000 : 40), 1'b1);
      check(op_done, 1'b1);
      run = 0;
    end
  end

  // Limit set well above the few thousand cycles the sequence needs.
  initial begin
    #3_000_000;
    errors++;
    print_verdict();
  end

  initial begin
    logic [7:0] d;
    void'($urandom(32'hC1DC4C97));
    {reset, spi_mode3, cmd_valid, wr_valid, otp_run} = 5'h10;
    {cmd_page, cmd_len, wr_data} = '0;
    cmd_op = OP_READ;
    foreach (mem[p, i]) mem[p][i] = 8'hFF;
    foreach (otp_m[i]) otp_m[i] = 8'hFF;
    repeat (8) @(posedge clk);
    #1 reset = 1'b0;
    for (int m = 0; m < 2; m++) begin
      spi_mode3 = m[0];
      repeat (2) @(posedge clk) #1;
      rd(4'h5, 0);
      prog(4'(m * 4 + 1), 8);
      rd(4'(m * 4 + 1), 0);
    end
    prog(4'h3, 32);
    rd(4'h3, 0);
    prog(4'h7, 1);
    rd(4'h7, 0);
    check(rewrite_ptr, 4'h1);
    otp_run = 1'b1;
    for (int i = 0; i < 8; i++) begin
      d = $urandom;
      otp_m[i] = otp_m[i] & d;
      push(d);
    end
    wr_valid = 1'b0;
    send(OP_OTP_PROGRAM, 8'h00, 8'h08);
    prog(4'h2, 8);
    otp_run = 1'b0;
    rd(4'h0, 1);
    rd(4'h2, 0);
    print_verdict();
  end
endmodule
